// >>> adc_sel_pkg.sv
package adc_sel_pkg;
    // register byte addresses
    localparam logic [11:0] off_src_clk   = 12'h000;
    localparam logic [11:0] off_ref_amp   = 12'h004;
    localparam logic [11:0] off_bandgap   = 12'h008;
    localparam logic [11:0] off_chan_sel  = 12'h00C;
    localparam logic [11:0] off_pin_func  = 12'h010;
    localparam logic [11:0] off_status    = 12'h014;
    // reset values
    localparam logic [7:0]  rst_byte      = 8'h00;
    localparam logic [15:0] rst_pin_func  = 16'h0000;
    // writable bit masks (unimplemented bits read zero)
    localparam logic [7:0]  mask_src_clk  = 8'hF7;
    localparam logic [7:0]  mask_ref_amp  = 8'h9F;
    localparam logic [7:0]  mask_bandgap  = 8'h01;
    localparam logic [7:0]  mask_chan_sel = 8'h0F;
    // field positions and channel count
    localparam int src_sel_lsb   = 4;
    localparam int amp_en_bit    = 7;
    localparam int amp_in_bit    = 4;
    localparam int ref_sel_lsb   = 2;
    localparam int num_channels  = 16;

    typedef enum logic [2:0] {
        src_ext, src_avdd, src_avdd_half, src_avdd_quarter,
        src_vr, src_vr_half, src_vr_quarter, src_gnd
    } src_kind_t;

    // switch controls to the analog front end
    typedef struct packed {
        logic [15:0] ext_chan_on;
        logic        avdd_on;
        logic        avdd_half_on;
        logic        avdd_quarter_on;
        logic        vr_on;
        logic        vr_half_on;
        logic        vr_quarter_on;
        logic        gnd_on;
        logic        ref_avdd_on;
        logic        ref_pin_on;
        logic        ref_amp_on;
        logic        amp_en;
        logic        amp_pin_in_on;
        logic        amp_bg_in_on;
        logic [1:0]  amp_gain;
        logic        bandgap_en;
    } analog_ctl_t;
endpackage

// >>> conv_clk_div.sv
`timescale 1ns/1ps
module conv_clk_div
    import adc_sel_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // divide select and enable pulse
    input  wire logic [2:0] div_sel,
    output logic            tick
);
    typedef struct packed {
        logic [6:0] cnt;
        logic       tick;
    } div_state_t;

    div_state_t s_q, s_d;
    logic [6:0] limit;

    always_comb begin
        limit = 7'((8'h01 << div_sel) - 8'h01);
        s_d = s_q;
        if (s_q.cnt >= limit) begin
            s_d.cnt  = 7'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt  = 7'(s_q.cnt + 7'h01);
            s_d.tick = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// >>> adc_input_ref_select_ctrl.sv
`timescale 1ns/1ps
module adc_input_ref_select_ctrl
    import adc_sel_pkg::*;
(
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // analog front end switches
    output analog_ctl_t      analog_ctl,
    // converter clock enable
    output logic             conv_clk_en,
    // pin mux: per-pin analog override
    output logic [15:0]      pin_analog_mode,
    output logic [15:0]      pin_func_disable,
    output logic [15:0]      pin_pullup_disable,
    output logic [15:0]      pin_dir_override
);
    typedef struct packed {
        logic [7:0]  src_clk;
        logic [7:0]  ref_amp;
        logic [7:0]  bandgap;
        logic [7:0]  chan_sel;
        logic [15:0] pin_func;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        analog_ctl_t ctl;
        logic [15:0] pin_mode;
        logic        clk_en;
    } ctrl_state_t;

    ctrl_state_t s_q, s_d;
    logic        tick;
    logic        wr_en;
    logic        rd_en;
    logic [3:0]  src_code;
    src_kind_t   src_kind;
    logic        hit;
    logic [31:0] rd_val;
    logic [15:0] chan_onehot;

    conv_clk_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .div_sel (s_q.src_clk[2:0]),
        .tick    (tick)
    );

    // channel decode, one switch per input
    genvar gi;
    generate
        for (gi = 0; gi < num_channels; gi++) begin : g_chan
            assign chan_onehot[gi] = (s_q.chan_sel[3:0] == 4'(gi));
        end
    endgenerate

    always_comb begin
        src_code = s_q.src_clk[src_sel_lsb +: 4];
        case (src_code)
            4'h0, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF: src_kind = src_ext;
            4'h1:                               src_kind = src_avdd;
            4'h2:                               src_kind = src_avdd_half;
            4'h3:                               src_kind = src_avdd_quarter;
            4'h5:                               src_kind = src_vr;
            4'h6:                               src_kind = src_vr_half;
            4'h7:                               src_kind = src_vr_quarter;
            4'h8, 4'h9, 4'hA, 4'hB:             src_kind = src_gnd;
            default:                            src_kind = src_gnd;
        endcase
    end

    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            off_src_clk:  rd_val = {24'h000000, s_q.src_clk};
            off_ref_amp:  rd_val = {24'h000000, s_q.ref_amp};
            off_bandgap:  rd_val = {24'h000000, s_q.bandgap};
            off_chan_sel: rd_val = {24'h000000, s_q.chan_sel};
            off_pin_func: rd_val = {16'h0000, s_q.pin_func};
            off_status:   rd_val = {5'h00, s_q.ctl.amp_en, s_q.ctl.bandgap_en,
                                    s_q.ctl.ext_chan_on, 1'b0, 4'(src_kind), 4'h0};
            default:      hit = 1'b0;
        endcase
    end

    assign wr_en = psel && penable && pwrite && s_q.ready;
    assign rd_en = psel && !penable;

    always_comb begin
        s_d = s_q;
        // one wait state: ready rises in the access phase
        s_d.ready  = psel && penable && !s_q.ready;
        s_d.slverr = psel && penable && !s_q.ready && !hit;
        if (rd_en) begin
            s_d.rdata = hit ? rd_val : 32'h0000_0000;
        end
        if (wr_en && hit) begin
            case (paddr)
                off_src_clk:  s_d.src_clk  = pwdata[7:0] & mask_src_clk;
                off_ref_amp:  s_d.ref_amp  = pwdata[7:0] & mask_ref_amp;
                off_bandgap:  s_d.bandgap  = pwdata[7:0] & mask_bandgap;
                off_chan_sel: s_d.chan_sel = pwdata[7:0] & mask_chan_sel;
                off_pin_func: s_d.pin_func = pwdata[15:0];
                default:      s_d.rdata    = s_q.rdata;
            endcase
        end
        s_d.clk_en = tick;

        // input routing, registered one edge behind the register
        s_d.ctl.ext_chan_on     = (src_kind == src_ext) ? chan_onehot : 16'h0000;
        s_d.ctl.avdd_on         = (src_kind == src_avdd);
        s_d.ctl.avdd_half_on    = (src_kind == src_avdd_half);
        s_d.ctl.avdd_quarter_on = (src_kind == src_avdd_quarter);
        s_d.ctl.vr_on           = (src_kind == src_vr);
        s_d.ctl.vr_half_on      = (src_kind == src_vr_half);
        s_d.ctl.vr_quarter_on   = (src_kind == src_vr_quarter);
        s_d.ctl.gnd_on          = (src_kind == src_gnd);

        // reference selection
        s_d.ctl.ref_avdd_on = (s_q.ref_amp[ref_sel_lsb +: 2] == 2'h0);
        s_d.ctl.ref_pin_on  = (s_q.ref_amp[ref_sel_lsb +: 2] == 2'h1);
        s_d.ctl.ref_amp_on  = s_q.ref_amp[ref_sel_lsb + 1];

        // amplifier
        s_d.ctl.amp_en        = s_q.ref_amp[amp_en_bit];
        s_d.ctl.amp_pin_in_on = !s_q.ref_amp[amp_in_bit];
        s_d.ctl.amp_bg_in_on  = s_q.ref_amp[amp_in_bit];
        s_d.ctl.amp_gain      = s_q.ref_amp[1:0];
        s_d.ctl.bandgap_en    = s_q.bandgap[0];

        s_d.pin_mode = s_q.pin_func;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.src_clk  <= rst_byte;
            s_q.ref_amp  <= rst_byte;
            s_q.bandgap  <= rst_byte;
            s_q.chan_sel <= rst_byte;
            s_q.pin_func <= rst_pin_func;
            s_q.ctl.amp_pin_in_on <= 1'b1;
            s_q.ctl.ref_avdd_on   <= 1'b1;
            s_q.ctl.ext_chan_on   <= 16'h0001;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata             = s_q.rdata;
    assign pready             = s_q.ready;
    assign pslverr            = s_q.slverr;
    assign analog_ctl         = s_q.ctl;
    assign conv_clk_en        = s_q.clk_en;
    assign pin_analog_mode    = s_q.pin_mode;
    assign pin_func_disable   = s_q.pin_mode;
    assign pin_pullup_disable = s_q.pin_mode;
    assign pin_dir_override   = s_q.pin_mode;
endmodule

// >>> analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model
    import adc_sel_pkg::*;
(
    // switch controls from the block
    input  wire analog_ctl_t ctl,
    // number of paths joined to the converter input
    output logic [4:0]       paths
);
    // more than one path would short sources together
    assign paths = 5'($countones({ctl.ext_chan_on, ctl.avdd_on, ctl.avdd_half_on,
        ctl.avdd_quarter_on, ctl.vr_on, ctl.vr_half_on, ctl.vr_quarter_on, ctl.gnd_on}));
endmodule

// >>> adc_sel_assertions.sv
`timescale 1ns/1ps
module adc_sel_checker
    import adc_sel_pkg::*;
(
    // apb
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // analog and pins
    input wire analog_ctl_t analog_ctl,
    input wire logic        conv_clk_en,
    input wire logic [15:0] pin_analog_mode, pin_func_disable, pin_pullup_disable, pin_dir_override
);
    wire logic       wr_done = psel && penable && pready && pwrite;
    wire logic [6:0] int_src = {analog_ctl.avdd_on, analog_ctl.avdd_half_on,
        analog_ctl.avdd_quarter_on, analog_ctl.vr_on, analog_ctl.vr_half_on,
        analog_ctl.vr_quarter_on, analog_ctl.gnd_on};
    wire logic [4:0] amp_word = {pwdata[7], pwdata[4], !pwdata[4], pwdata[1:0]};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ext_off; |int_src |-> analog_ctl.ext_chan_on == 16'h0000; endproperty
    property p_one_path; $onehot({analog_ctl.ext_chan_on, int_src}); endproperty
    property p_ref; $onehot({analog_ctl.ref_avdd_on, analog_ctl.ref_pin_on, analog_ctl.ref_amp_on});
    endproperty
    property p_amp; wr_done && paddr == off_ref_amp |-> ##2 {analog_ctl.amp_en,
        analog_ctl.amp_bg_in_on, analog_ctl.amp_pin_in_on, analog_ctl.amp_gain} == $past(amp_word, 2);
    endproperty
    property p_gnd; wr_done && paddr == off_src_clk && pwdata[7:6] == 2'b10
        |-> ##2 analog_ctl.gnd_on && analog_ctl.ext_chan_on == 16'h0000; endproperty
    property p_pins; pin_analog_mode == pin_func_disable && pin_analog_mode == pin_pullup_disable
        && pin_analog_mode == pin_dir_override; endproperty
    property p_upd; !$stable(analog_ctl) |-> $past(wr_done, 2); endproperty
    property p_clk; conv_clk_en |-> ##[1:128] conv_clk_en; endproperty
    property p_ready; pready |-> psel && penable ##1 !pready; endproperty
    a_ext_off: assert property (p_ext_off) else $error("channel on with internal source");
    a_one_path: assert property (p_one_path) else $error("not one input path");
    a_ref: assert property (p_ref) else $error("not one reference");
    a_amp: assert property (p_amp) else $error("amplifier controls wrong");
    a_gnd: assert property (p_gnd) else $error("ground code not grounded");
    a_pins: assert property (p_pins) else $error("pin overrides differ");
    a_upd: assert property (p_upd) else $error("switches moved without write");
    a_clk: assert property (p_clk) else $error("converter clock gap too long");
    a_ready: assert property (p_ready) else $error("bad ready pulse");
    c_gnd: cover property (analog_ctl.gnd_on);
    c_bg: cover property (analog_ctl.amp_bg_in_on);
    c_err: cover property (pslverr);
endmodule
bind adc_input_ref_select_ctrl adc_sel_checker u_adc_sel_checker (.*);

// >>> adc_input_ref_select_ctrl_test.sv
`timescale 1ns/1ps
module adc_input_ref_select_ctrl_test;
    import adc_sel_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, conv_clk_en, e;
    logic [15:0] pam, pfd, ppd, pdo;
    logic [4:0]  paths;
    logic [7:0]  x;
    logic [2:0]  rx;
    analog_ctl_t ac;
    int          mismatches = 0, checked = 0, cyc = 0, n;
    // cycles given to the bandgap to settle before it is used as amplifier input
    localparam int bg_settle = 200;
    always #5 pclk = ~pclk;
    adc_input_ref_select_ctrl u_adc_input_ref_select_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_ctl(ac),
        .conv_clk_en(conv_clk_en), .pin_analog_mode(pam), .pin_func_disable(pfd),
        .pin_pullup_disable(ppd), .pin_dir_override(pdo));
    analog_front_model u_analog_front_model (.ctl(ac), .paths(paths));
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic gap();
        n = 0;
        do begin @(posedge pclk); n++; end while (conv_clk_en !== 1'b1 && n < 300);
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 8000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset ctl", ac, 32'h0001_0110);
        for (int i = 0; i < 5; i++) begin apb(0, 12'(4 * i), 0); chk("reset reg", r, 0); end
        // bandgap first, then the register that selects it as amplifier input
        for (int i = 2; i >= 0; i--) begin
            apb(1, 12'(4 * i), 32'hFFFFFFFF);
            if (i == 2) repeat (bg_settle) @(posedge pclk);
            apb(0, 12'(4 * i), 0);
            chk("mask", r, i == 0 ? 32'hF7 : i == 1 ? 32'h9F : 32'h01);
        end
        chk("bandgap", ac.bandgap_en, 1);
        apb(1, 12'h020, 32'hFF);
        chk("slverr", e, 1);
        $display("test registers done");
        apb(1, off_chan_sel, 32'h5);
        for (int c = 0; c < 16; c++) begin
            apb(1, off_src_clk, 32'(c << 4));
            case (c)
                0, 4, 12, 13, 14, 15: x = 8'h80;
                1, 2, 3: x = 8'h80 >> c;
                5, 6, 7: x = 8'h08 >> (c - 5);
                default: x = 8'h01;
            endcase
            chk("source", {ac.avdd_on, ac.avdd_half_on, ac.avdd_quarter_on,
                ac.vr_on, ac.vr_half_on, ac.vr_quarter_on, ac.gnd_on}, x[6:0]);
            chk("chan", ac.ext_chan_on, x[7] ? 16'h0020 : 16'h0000);
            chk("paths", paths, 1);
        end
        apb(1, off_src_clk, 0);
        for (int c = 0; c < 16; c++) begin
            apb(1, off_chan_sel, 32'(c));
            chk("chan n", ac.ext_chan_on, 16'h1 << c);
        end
        $display("test source done");
        for (int i = 0; i < 64; i++) begin
            apb(1, off_ref_amp, {24'h0, i[5], 2'b11, i[4:0]});
            rx = i[3] ? 3'b001 : i[2] ? 3'b010 : 3'b100;
            chk("ref amp", {ac.amp_en, ac.amp_pin_in_on, ac.amp_bg_in_on, ac.ref_avdd_on,
                ac.ref_pin_on, ac.ref_amp_on, ac.amp_gain}, {i[5], ~i[4], i[4], rx, i[1:0]});
            apb(0, off_ref_amp, 0);
            chk("ref rd", r, {i[5], 2'b00, i[4:0]});
        end
        $display("test reference done");
        for (int d = 0; d < 8; d += 3) begin
            apb(1, off_src_clk, 32'(d));
            gap();
            gap();
            gap();
            chk("div", n, 1 << d);
        end
        apb(1, off_pin_func, 32'hFFFFA5A5);
        chk("pins", {pam, pfd, ppd, pdo}, {4{16'hA5A5}});
        apb(0, off_pin_func, 0);
        chk("pin rd", r, 32'h0000A5A5);
        // status: amplifier on, bandgap on, channel 15 on, external source
        apb(0, off_status, 0);
        chk("status", r, 32'h0700_0000);
        $display("test clock and pins done");
        complete_run();
    end
endmodule
